// file: clm_board.sv
// Purpose: board-side model of the eight cell pins
// Assumes: each pin has a pull-up; the tester drives only where told to
// Notes:   a released pin reads high, never a stale copy of the last drive
`timescale 1ns/1ps
module clm_board (
   input  wire logic [7:0] io_out,
   input  wire logic [7:0] io_oe,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] io_in
);
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (io_oe[i])
            io_in[i] = io_out[i];
         else if (ext_en[i])
            io_in[i] = ext_val[i];  // Tester forces the pin
         else
            io_in[i] = 1'b1;        // Pull-up, so an unknown never hides
      end
   end
endmodule

// file: clm_macrocell_array.sv
// Purpose: eight configurable sum-of-products macrocells behind an AXI4-Lite slave
// Assumes: all pin inputs synchronous to clk; reset stands for power-up
// Notes:   pin outputs are registered, so combinatorial results appear one clk later
// How it works
// - Non-registered, mode 0, cell bit 0: output sums eight terms, always enabled.
// - That output feeds back, except the two centre cells.
// - Non-registered, mode 0, cell bit 1: buffer off, adjacent pin fed back.
// - Non-registered, mode 1, cell bit 1: seven terms summed, eighth enables buffer.
// - Combinatorial I/O feeds its pin level back into the array.
// - Registered device, cell bit 1: seven terms summed, eighth drives enable.
// - Combinatorial I/O in registered device feeds back its own pin.
// - Power-up clears every cell flip-flop low on a clk edge while reset is high.
// - Registered outputs show high after power-up through the inverting path.
// - Combinatorial outputs show their logic function after power-up.
// - Test may load any state into the registers from the pins.
// - Once secured, term pattern reads are refused.
// - Security bit clears only together with a full erase.
// - A 64-bit user signature word is held.
// - Signature is readable whatever the security bit.
// - A control erase write clears terms, configuration, signature and security.
// - Registered cells capture on clock pin rise; enable pin drives buffer.
// - Polarity bit XORs the sum; one inverts.
// - End cells steer feedback by the register-allow bit instead.
// - Clock and enable pins reach the array only without registers.
`timescale 1ns/1ps
module clm_macrocell_array #(
   parameter int N_IN = clm_pkg::NIN
) (
   input  wire logic                           clk,
   input  wire logic                           reset,
   input  wire logic [clm_pkg::ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                           s_axi_awvalid,
   output logic                                s_axi_awready,
   input  wire logic [31:0]                    s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   input  wire logic                           s_axi_wvalid,
   output logic                                s_axi_wready,
   output logic [1:0]                          s_axi_bresp,
   output logic                                s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   input  wire logic [clm_pkg::ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                           s_axi_arvalid,
   output logic                                s_axi_arready,
   output logic [31:0]                         s_axi_rdata,
   output logic [1:0]                          s_axi_rresp,
   output logic                                s_axi_rvalid,
   input  wire logic                           s_axi_rready,
   input  wire logic [N_IN-1:0]                in_pin,
   input  wire logic                           clk_pin,
   input  wire logic                           oe_n_pin,
   input  wire logic                           preload,
   input  wire logic [clm_pkg::NCELL-1:0]      io_in,
   output logic [clm_pkg::NCELL-1:0]           io_out,
   output logic [clm_pkg::NCELL-1:0]           io_oe
);
   localparam int AIN_W = N_IN + 2 + clm_pkg::NCELL;

   clm_pkg::clm_cfg_s           cfg_reg, cfg_next;
   logic                        sec_reg, sec_next;
   logic [63:0]                 sig_reg, sig_next;
   logic [AIN_W-1:0]            t_mask [clm_pkg::NTERM];
   logic [AIN_W-1:0]            c_mask [clm_pkg::NTERM];
   logic                        aw_rdy_reg, aw_rdy_next, w_rdy_reg, w_rdy_next;
   logic                        b_vld_reg, b_vld_next, ar_rdy_reg, ar_rdy_next;
   logic                        r_vld_reg, r_vld_next;
   logic [1:0]                  bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0]                 rdata_reg, rdata_next, wdata_reg, wdata_next, wv;
   logic [3:0]                  wstrb_reg, wstrb_next;
   logic [11:0]                 awaddr_reg, awaddr_next;
   logic                        do_wr, erase_now, term_we;
   logic [clm_pkg::NCELL-1:0]   q_reg, q_next, out_reg, out_next, oe_reg, oe_next, fb;
   logic                        clkp_reg, rise;
   logic [AIN_W-1:0]            ain;
   logic [clm_pkg::NCELL-1:0][clm_pkg::PT_PER_CELL-1:0] pt;
   clm_pkg::clm_kind_e          kind [clm_pkg::NCELL];

   function automatic logic term_hit(input logic [11:0] a);
      return a >= clm_pkg::TERM_BASE && a <= clm_pkg::TERM_LAST;
   endfunction

   function automatic logic [5:0] term_idx(input logic [11:0] a);
      logic [11:0] d;
      d = a - clm_pkg::TERM_BASE;
      return d[8:3];
   endfunction

   function automatic logic addr_ok(input logic [11:0] a);
      return a[1:0] == 2'h0 && (a == clm_pkg::CFG_OFF || a == clm_pkg::CTRL_OFF
         || a == clm_pkg::STAT_OFF || a == clm_pkg::SIG_LO_OFF
         || a == clm_pkg::SIG_HI_OFF || term_hit(a));
   endfunction

   function automatic logic [31:0] rd_word(input logic [11:0] a);
      logic [31:0] r;
      r = 32'h0;
      if (a == clm_pkg::CFG_OFF) begin
         r[clm_pkg::CFG_ALLOW_BIT] = cfg_reg.allow;
         r[clm_pkg::CFG_MODE_BIT] = cfg_reg.mode;
         r[clm_pkg::CFG_CELL_LSB +: 8] = cfg_reg.cell_cfg;
         r[clm_pkg::CFG_POL_LSB +: 8] = cfg_reg.pol;
      end else if (a == clm_pkg::CTRL_OFF) begin
         r[clm_pkg::CTRL_SEC_BIT] = sec_reg;
      end else if (a == clm_pkg::STAT_OFF) begin
         r[clm_pkg::STAT_Q_LSB +: 8] = q_reg;
         r[clm_pkg::STAT_OE_LSB +: 8] = oe_reg;
         r[clm_pkg::STAT_SEC_BIT] = sec_reg;
      end else if (a == clm_pkg::SIG_LO_OFF) begin
         r = sig_reg[31:0];
      end else if (a == clm_pkg::SIG_HI_OFF) begin
         r = sig_reg[63:32];
      end else if (term_hit(a) && !sec_reg) begin
         r[AIN_W-1:0] = a[2] ? c_mask[term_idx(a)] : t_mask[term_idx(a)];
      end
      return r;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = n[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic clm_pkg::clm_kind_e cell_kind(input int i);
      logic [2:0] k;
      k = {cfg_reg.allow, cfg_reg.mode, cfg_reg.cell_cfg[i]};
      unique case (k)
         3'h2:    return clm_pkg::CK_REG;
         3'h3:    return clm_pkg::CK_CIO;
         3'h4:    return clm_pkg::CK_OUT;
         3'h5:    return clm_pkg::CK_IN;
         3'h7:    return clm_pkg::CK_CIO;
         default: return clm_pkg::CK_BAD;
      endcase
   endfunction

   // Kinds as signals, so assertions see the sampled configuration
   always_comb begin
      for (int i = 0; i < clm_pkg::NCELL; i++) begin
         kind[i] = cell_kind(i);
      end
   end

   // Bus slave and register file
   always_comb begin
      aw_rdy_next = aw_rdy_reg;
      w_rdy_next  = w_rdy_reg;
      b_vld_next  = b_vld_reg;
      bresp_next  = bresp_reg;
      ar_rdy_next = ar_rdy_reg;
      r_vld_next  = r_vld_reg;
      rresp_next  = rresp_reg;
      rdata_next  = rdata_reg;
      awaddr_next = awaddr_reg;
      wdata_next  = wdata_reg;
      wstrb_next  = wstrb_reg;
      cfg_next    = cfg_reg;
      sec_next    = sec_reg;
      sig_next    = sig_reg;
      erase_now   = 1'b0;
      term_we     = 1'b0;
      do_wr       = !aw_rdy_reg && !w_rdy_reg && !b_vld_reg;
      wv          = merge(rd_word(awaddr_reg), wdata_reg, wstrb_reg);
      if (s_axi_awvalid && aw_rdy_reg) begin
         aw_rdy_next = 1'b0;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && w_rdy_reg) begin
         w_rdy_next = 1'b0;
         wdata_next = s_axi_wdata;
         wstrb_next = s_axi_wstrb;
      end
      if (do_wr) begin
         b_vld_next = 1'b1;
         bresp_next = addr_ok(awaddr_reg) ? clm_pkg::RESP_OKAY : clm_pkg::RESP_SLVERR;
         if (addr_ok(awaddr_reg)) begin
            if (awaddr_reg == clm_pkg::CFG_OFF) begin
               cfg_next.allow    = wv[clm_pkg::CFG_ALLOW_BIT];
               cfg_next.mode     = wv[clm_pkg::CFG_MODE_BIT];
               cfg_next.cell_cfg = wv[clm_pkg::CFG_CELL_LSB +: 8];
               cfg_next.pol      = wv[clm_pkg::CFG_POL_LSB +: 8];
            end else if (awaddr_reg == clm_pkg::CTRL_OFF) begin
               // Erase first, so an erasing write may also re-secure
               if (wv[clm_pkg::CTRL_ERASE_BIT]) begin
                  erase_now = 1'b1;
                  cfg_next  = clm_pkg::CFG_RST;
                  sig_next  = clm_pkg::SIG_RST;
                  sec_next  = 1'b0;
               end
               if (wv[clm_pkg::CTRL_SEC_BIT]) begin
                  sec_next = 1'b1;
               end
            end else if (awaddr_reg == clm_pkg::SIG_LO_OFF) begin
               sig_next[31:0] = wv;
            end else if (awaddr_reg == clm_pkg::SIG_HI_OFF) begin
               sig_next[63:32] = wv;
            end else if (term_hit(awaddr_reg)) begin
               term_we = 1'b1;
            end
         end
      end
      if (b_vld_reg && s_axi_bready) begin
         b_vld_next  = 1'b0;
         aw_rdy_next = 1'b1;
         w_rdy_next  = 1'b1;
      end
      if (s_axi_arvalid && ar_rdy_reg) begin
         ar_rdy_next = 1'b0;
         r_vld_next  = 1'b1;
         rdata_next  = rd_word(s_axi_araddr);
         rresp_next  = (!addr_ok(s_axi_araddr) || (term_hit(s_axi_araddr) && sec_reg))
                       ? clm_pkg::RESP_SLVERR : clm_pkg::RESP_OKAY;
      end
      if (r_vld_reg && s_axi_rready) begin
         r_vld_next  = 1'b0;
         ar_rdy_next = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         aw_rdy_reg <= 1'b1;
         w_rdy_reg  <= 1'b1;
         b_vld_reg  <= 1'b0;
         bresp_reg  <= clm_pkg::RESP_OKAY;
         ar_rdy_reg <= 1'b1;
         r_vld_reg  <= 1'b0;
         rresp_reg  <= clm_pkg::RESP_OKAY;
         rdata_reg  <= 32'h0;
         awaddr_reg <= 12'h0;
         wdata_reg  <= 32'h0;
         wstrb_reg  <= 4'h0;
         cfg_reg    <= clm_pkg::CFG_RST;
         sec_reg    <= 1'b0;
         sig_reg    <= clm_pkg::SIG_RST;
      end else begin
         aw_rdy_reg <= aw_rdy_next;
         w_rdy_reg  <= w_rdy_next;
         b_vld_reg  <= b_vld_next;
         bresp_reg  <= bresp_next;
         ar_rdy_reg <= ar_rdy_next;
         r_vld_reg  <= r_vld_next;
         rresp_reg  <= rresp_next;
         rdata_reg  <= rdata_next;
         awaddr_reg <= awaddr_next;
         wdata_reg  <= wdata_next;
         wstrb_reg  <= wstrb_next;
         cfg_reg    <= cfg_next;
         sec_reg    <= sec_next;
         sig_reg    <= sig_next;
      end
   end

   // Term memory; cleared words act as always-true terms
   always_ff @(posedge clk) begin
      if (reset || erase_now) begin
         for (int t = 0; t < clm_pkg::NTERM; t++) begin
            t_mask[t] <= '0;
            c_mask[t] <= '0;
         end
      end else if (term_we) begin
         if (awaddr_reg[2]) begin
            c_mask[term_idx(awaddr_reg)] <= wv[AIN_W-1:0];
         end else begin
            t_mask[term_idx(awaddr_reg)] <= wv[AIN_W-1:0];
         end
      end
   end

   // Feedback taken from registers and pins only, so the array has no loop
   always_comb begin
      for (int i = 0; i < clm_pkg::NCELL; i++) begin
         fb[i] = 1'b0;
         if (cell_kind(i) != clm_pkg::CK_BAD) begin
            unique case ({(i == 0 || i == clm_pkg::NCELL - 1) ? !cfg_reg.allow
                          : cfg_reg.mode, cfg_reg.cell_cfg[i]})
               2'h2: fb[i] = q_reg[i];
               2'h3: fb[i] = io_in[i];
               2'h1: fb[i] = io_in[i ^ 1];
               2'h0: fb[i] = (i == clm_pkg::CENTRE_LO || i == clm_pkg::CENTRE_HI)
                             ? 1'b0 : out_reg[i];
            endcase
         end
      end
   end

   assign ain = {fb, cfg_reg.allow ? {oe_n_pin, clk_pin} : 2'h0, in_pin};

   for (genvar i = 0; i < clm_pkg::NCELL; i++) begin : g_cell
      for (genvar k = 0; k < clm_pkg::PT_PER_CELL; k++) begin : g_term
         localparam int T = i * clm_pkg::PT_PER_CELL + k;
         assign pt[i][k] = ((ain & t_mask[T]) == t_mask[T])
                           && ((~ain & c_mask[T]) == c_mask[T]);
      end
   end

   // Cell registers and pin drivers
   always_comb begin
      logic s8;
      logic s7;
      s8   = 1'b0;
      s7   = 1'b0;
      rise = clk_pin && !clkp_reg;
      for (int i = 0; i < clm_pkg::NCELL; i++) begin
         s8 = (|pt[i]) ^ cfg_reg.pol[i];
         s7 = (|pt[i][6:0]) ^ cfg_reg.pol[i];
         q_next[i]   = q_reg[i];
         out_next[i] = out_reg[i];
         oe_next[i]  = 1'b0;
         unique case (cell_kind(i))
            clm_pkg::CK_REG: begin
               q_next[i]  = rise ? s8 : q_reg[i];
               oe_next[i] = !oe_n_pin;
            end
            clm_pkg::CK_CIO: begin
               out_next[i] = s7;
               oe_next[i]  = pt[i][7];
            end
            clm_pkg::CK_OUT: begin
               out_next[i] = s8;
               oe_next[i]  = 1'b1;
            end
            default: begin
            end
         endcase
         if (preload) begin
            q_next[i]  = io_in[i];
            oe_next[i] = 1'b0;
         end
         if (cell_kind(i) == clm_pkg::CK_REG) begin
            out_next[i] = !q_next[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q_reg    <= clm_pkg::Q_RST;
         out_reg  <= clm_pkg::OUT_RST;
         oe_reg   <= 8'h00;
         clkp_reg <= 1'b0;
      end else begin
         q_reg    <= q_next;
         out_reg  <= out_next;
         oe_reg   <= oe_next;
         clkp_reg <= clk_pin;
      end
   end

   assign s_axi_awready = aw_rdy_reg;
   assign s_axi_wready  = w_rdy_reg;
   assign s_axi_bvalid  = b_vld_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = ar_rdy_reg;
   assign s_axi_rvalid  = r_vld_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;
   assign io_out        = out_reg;
   assign io_oe         = oe_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_reset_state:
   assert property ($fell(reset) |-> q_reg == 8'h00 && io_out == 8'hff && io_oe == 8'h00)
      else $error("Bad state after reset");
   a_preload_load:
   assert property (preload |=> q_reg == $past(io_in) && io_oe == 8'h00)
      else $error("Preload did not load pins");
   a_reg_capture:
   assert property (kind[0] == clm_pkg::CK_REG && rise && !preload
                    |=> q_reg[0] == ((|$past(pt[0])) ^ $past(cfg_reg.pol[0])))
      else $error("Register missed clock pin edge");
   a_reg_hold:
   assert property (kind[0] == clm_pkg::CK_REG && !rise && !preload
                    && $stable(cfg_reg) |=> $stable(q_reg[0]) ##0 io_out[0] == !q_reg[0])
      else $error("Register changed without edge");
   a_comb_out:
   assert property (kind[1] == clm_pkg::CK_OUT && !preload
                    |=> io_oe[1] && io_out[1] == ((|$past(pt[1])) ^ $past(cfg_reg.pol[1])))
      else $error("Combinatorial output wrong");
   a_cio_enable:
   assert property (kind[2] == clm_pkg::CK_CIO && !preload
                    |=> io_oe[2] == $past(pt[2][7])
                    && io_out[2] == ((|$past(pt[2][6:0])) ^ $past(cfg_reg.pol[2])))
      else $error("Product term enable wrong");
   a_input_off:
   assert property (kind[2] == clm_pkg::CK_IN |=> !io_oe[2])
      else $error("Dedicated input drove pin");
   a_bad_off:
   assert property (kind[5] == clm_pkg::CK_BAD |=> !io_oe[5])
      else $error("Invalid configuration drove pin");
   a_centre_nofb:
   assert property (kind[3] == clm_pkg::CK_OUT && kind[2] == clm_pkg::CK_OUT
                    |-> !fb[3] && fb[2] == out_reg[2])
      else $error("Centre cell feedback wrong");
   a_end_fb:
   assert property (cfg_reg.allow && cfg_reg.mode && cfg_reg.cell_cfg[0] && cfg_reg.cell_cfg[7]
                    |-> fb[0] == io_in[1] && fb[7] == io_in[6])
      else $error("End cell feedback wrong");
   a_pins_masked:
   assert property (!cfg_reg.allow |-> ain[N_IN+1:N_IN] == 2'h0)
      else $error("Clock pins reached array");
   a_sec_sticky:
   assert property (sec_reg && !erase_now |=> sec_reg)
      else $error("Security cleared without erase");
   a_sec_refuse:
   assert property (s_axi_arvalid && ar_rdy_reg && term_hit(s_axi_araddr) && sec_reg
                    |=> s_axi_rvalid && s_axi_rdata == 32'h0
                    && s_axi_rresp == clm_pkg::RESP_SLVERR)
      else $error("Secured pattern was read");
   a_sig_read:
   assert property (s_axi_arvalid && ar_rdy_reg && s_axi_araddr == clm_pkg::SIG_LO_OFF
                    |=> s_axi_rresp == clm_pkg::RESP_OKAY && s_axi_rdata == $past(sig_reg[31:0]))
      else $error("Signature read failed");
   a_erase_all:
   assert property (erase_now |=> cfg_reg == clm_pkg::CFG_RST && sig_reg == 64'h0)
      else $error("Erase incomplete");

   c_preload: cover property (preload ##1 !preload);
   c_secured_read: cover property (sec_reg && s_axi_rvalid && s_axi_rresp == clm_pkg::RESP_SLVERR);
   c_reg_capture: cover property (kind[0] == clm_pkg::CK_REG && rise ##1 q_reg[0]);
endmodule

// file: clm_pkg.sv
// Purpose: shared constants and types for the configurable logic macrocell array
// Assumes: AXI4-Lite register access, 32-bit data, 12-bit byte addresses
// Notes:   cell kinds are decoded from the two global bits and one bit per cell
package clm_pkg;
   localparam int NCELL       = 8;
   localparam int NIN         = 12;
   localparam int PT_PER_CELL = 8;
   localparam int NTERM       = 64;
   localparam int ADDR_W      = 12;

   localparam logic [11:0] CFG_OFF    = 12'h000;
   localparam logic [11:0] CTRL_OFF   = 12'h004;
   localparam logic [11:0] STAT_OFF   = 12'h008;
   localparam logic [11:0] SIG_LO_OFF = 12'h010;
   localparam logic [11:0] SIG_HI_OFF = 12'h014;
   localparam logic [11:0] TERM_BASE  = 12'h100;
   localparam logic [11:0] TERM_LAST  = 12'h2fc;

   localparam int CFG_ALLOW_BIT  = 0;
   localparam int CFG_MODE_BIT   = 1;
   localparam int CFG_CELL_LSB   = 8;
   localparam int CFG_POL_LSB    = 16;
   localparam int CTRL_SEC_BIT   = 0;
   localparam int CTRL_ERASE_BIT = 1;
   localparam int STAT_Q_LSB     = 0;
   localparam int STAT_OE_LSB    = 8;
   localparam int STAT_SEC_BIT   = 16;
   localparam int CENTRE_LO      = 3;
   localparam int CENTRE_HI      = 4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       allow;
      logic       mode;
      logic [7:0] cell_cfg;
      logic [7:0] pol;
   } clm_cfg_s;

   typedef enum logic [2:0] {CK_REG, CK_CIO, CK_OUT, CK_IN, CK_BAD} clm_kind_e;

   localparam clm_cfg_s    CFG_RST = clm_cfg_s'(18'h00000);
   localparam logic [7:0]  Q_RST   = 8'h00;
   localparam logic [7:0]  OUT_RST = 8'hff;
   localparam logic [63:0] SIG_RST = 64'h0;
endpackage

// file: configurable_logic_macrocell_bench.sv
// Purpose: directed bench for the macrocell array over its register bus and pins
// Assumes: terms erased by reset are always true; responses per the package
// Notes:   pin checks wait a few edges since pin outputs lag one clock
`timescale 1ns/1ps
module configurable_logic_macrocell_bench;
   logic        clk, reset, awv, wv, bry, arv, rry, awr, wrdy, bv, arr, rv;
   logic        clk_pin, oe_n_pin, preload;
   logic [11:0] awa, ara, ta, in_pin;
   logic [31:0] wd, rdat, cfgv;
   logic [1:0]  br, rr;
   logic [7:0]  io_in, io_out, io_oe, ext_en, ext_val;
   int          bad_count, n_checks;

   clm_macrocell_array dut_u (.clk(clk), .reset(reset), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .in_pin(in_pin), .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .preload(preload),
      .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
   clm_board board_u (.io_out(io_out), .io_oe(io_oe), .ext_en(ext_en),
      .ext_val(ext_val), .io_in(io_in));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er = clm_pkg::RESP_OKAY);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awr)
            awv <= 1'b0;
         if (wv && wrdy)
            wv <= 1'b0;
      end while (bv !== 1'b1);
      // Ready left high, so a back-to-back call never drives it twice
      chk(32'(br), 32'(er));
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                     input logic [1:0] er = clm_pkg::RESP_OKAY);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr)
            arv <= 1'b0;
      end while (rv !== 1'b1);
      chk(rdat, ed);
      chk(32'(rr), 32'(er));
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic tend(input string s);
      $display("test %s done", s);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Generous span; the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end

   initial begin
      {reset, awv, wv, bry, arv, rry, clk_pin, preload} = 8'h80;
      {awa, ara, in_pin, wd} = '0;
      {oe_n_pin, ext_en, ext_val} = 17'h10000;
      bad_count = 0;
      n_checks = 0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk(io_out, 8'hff);
      chk(io_oe, 8'h00);
      rd(clm_pkg::STAT_OFF, 32'h0);
      tend("reset");
      wr(clm_pkg::SIG_LO_OFF, 32'h89abcdef);
      wr(clm_pkg::SIG_HI_OFF, 32'h01234567);
      wr(clm_pkg::CTRL_OFF, 32'h1);
      rd(clm_pkg::SIG_LO_OFF, 32'h89abcdef);
      rd(clm_pkg::SIG_HI_OFF, 32'h01234567);
      rd(clm_pkg::TERM_BASE, 32'h0, clm_pkg::RESP_SLVERR);
      wr(clm_pkg::CTRL_OFF, 32'h0);
      rd(clm_pkg::STAT_OFF, 32'h00010000);
      wr(clm_pkg::CTRL_OFF, 32'h2);
      rd(clm_pkg::STAT_OFF, 32'h0);
      rd(clm_pkg::SIG_LO_OFF, 32'h0);
      rd(12'h00c, 32'h0, clm_pkg::RESP_SLVERR);
      wr(12'h00c, 32'hffffffff, clm_pkg::RESP_SLVERR);
      tend("security");
      wr(clm_pkg::CFG_OFF, 32'h00000002);
      oe_n_pin <= 1'b0;
      ext_en <= 8'hff;
      ext_val <= 8'h5a;
      preload <= 1'b1;
      cyc(3);
      chk(io_oe, 8'h00);
      preload <= 1'b0;
      ext_en <= 8'h00;
      cyc(3);
      chk(io_out, 8'ha5);
      chk(io_oe, 8'hff);
      rd(clm_pkg::STAT_OFF, 32'h0000ff5a);
      clk_pin <= 1'b1;
      cyc(3);
      chk(io_out, 8'h00);
      wr(clm_pkg::CFG_OFF, 32'h000f0002);
      clk_pin <= 1'b0;
      cyc(2);
      clk_pin <= 1'b1;
      cyc(3);
      chk(io_out, 8'h0f);
      tend("registered");
      oe_n_pin <= 1'b1;
      wr(clm_pkg::CFG_OFF, 32'h00000001);
      cyc(3);
      chk(io_oe, 8'hff);
      chk(io_out, 8'hff);
      wr(clm_pkg::CFG_OFF, 32'h000f0001);
      cyc(3);
      chk(io_out, 8'hf0);
      wr(clm_pkg::CFG_OFF, 32'h0000ff01);
      cyc(3);
      chk(io_oe, 8'h00);
      tend("combinatorial");
      // Cell 2 enable follows input 0; cell 3 sums only its pin-2 feedback term
      wr(12'h1b8, 32'h1);
      wr(12'h1c0, 32'h00010000);
      for (int k = 1; k < 7; k++) begin
         ta = 12'h1c0 + 12'(8 * k);
         wr(ta, 32'h1);
         wr(ta + 12'h4, 32'h1);
      end
      ext_en <= 8'h04;
      for (int c = 0; c < 2; c++) begin
         cfgv = (c == 0) ? 32'h0000ff03 : 32'h0000ff02;
         wr(clm_pkg::CFG_OFF, cfgv);
         for (int v = 0; v < 2; v++) begin
            ext_val <= 8'(v << 2);
            cyc(4);
            chk(io_oe, 8'hfb);
            chk(32'(io_out[3]), 32'(v));
         end
         in_pin <= 12'h001;
         cyc(3);
         chk(io_oe, 8'hff);
         in_pin <= 12'h000;
      end
      tend("io");
      tally_and_finish();
   end
endmodule
